//--- hw/urr_receiver.sv
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
module urr_receiver #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // Serial line
  input  wire logic                      serial_in,
  // AXI4-Lite write address and data
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [urr_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                      wvalid,
  output logic                           wready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  // AXI4-Lite write response
  output logic                           bvalid,
  input  wire logic                      bready,
  output logic [1:0]                     bresp,
  // AXI4-Lite read
  input  wire logic                      arvalid,
  output logic                           arready,
  input  wire logic [urr_pkg::ADDR_W-1:0] araddr,
  output logic                           rvalid,
  input  wire logic                      rready,
  output logic [31:0]                    rdata,
  output logic [1:0]                     rresp,
  // Interrupt requests
  output logic                           rx_irq,
  output logic                           err_irq
);
  import urr_pkg::*;

  logic                rx_meta;
  logic                rx_sync;
  logic                prev_sample;
  logic                sample;
  logic                tick;
  urr_state_type       state;
  logic [4:0]          rt;
  logic [1:0]          ones_cnt;
  logic [3:0]          bit_idx;
  logic [1:0]          votes;
  logic                noise_acc;
  logic                last_bit;
  logic [8:0]          shift;
  urr_ctrl_type        ctrl;
  urr_c2_type          c2;
  urr_c3_type          c3;
  logic [DIV_W-1:0]    divisor;
  logic [8:0]          data_buffer;
  logic                full_flag;
  logic                idle_flag;
  logic                overrun_flag;
  logic                noise_flag;
  logic                framing_flag;
  logic                parity_flag;
  logic [3:0]          quiet_ticks;
  logic [3:0]          quiet_bits;
  logic                idle_armed;
  logic [ADDR_W-1:0]   wr_addr;
  logic [31:0]         wr_data;
  logic [3:0]          wr_strb;
  logic                aw_ok;
  logic                w_ok;
  logic [1:0]          vote_ones;
  logic                vote_bit;
  logic                vote_mixed;
  logic                start_found;
  logic                bit_event;
  logic                char_done;
  logic                resync;
  logic [3:0]          last_idx;
  logic [3:0]          frame_len;
  logic                msb;
  logic                par_err;
  logic                idle_hit;
  logic                wake_addr;
  logic                wake_idle;
  logic                accept;
  logic                set_new;
  logic                idle_event;
  logic                do_write;
  logic                rd_take;
  logic                rd_clear_full;
  logic [SB_COUNT-1:0] status_word;
  logic [SB_COUNT-1:0] clr;
  logic [31:0]         rd_word;
  logic                rd_ok;
  logic                wr_ok;

  // Two-stage synchroniser, line idles high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= serial_in;
      rx_sync <= rx_meta;
    end
  end

  assign sample = rx_sync;

  urr_tick_gen #(
    .DIV_W   (DIV_W)
  ) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .divisor (divisor),
    .tick    (tick)
  );

  assign vote_ones  = {1'b0, votes[0]} + {1'b0, votes[1]} + {1'b0, sample};
  assign vote_bit   = vote_ones >= 2'h2;
  assign vote_mixed = (vote_ones != 2'h0) && (vote_ones != 2'h3);
  assign last_idx   = ctrl.nine_bit ? LAST_BIT_9 : LAST_BIT_8;
  assign frame_len  = ctrl.nine_bit ? FRAME_LEN_9 : FRAME_LEN_8;
  assign msb        = ctrl.nine_bit ? shift[8] : shift[7];
  // Bit 8 stays clear in 8-bit mode, so parity covers all of shift
  assign par_err    = ctrl.parity_on && ((^shift) != ctrl.odd_parity_select);

  assign start_found = tick && ctrl.rx_on && state == ST_HUNT && !sample
                       && ones_cnt == 2'h3;
  assign bit_event   = tick && (state == ST_DATA || state == ST_STOP) && rt == RT_10;
  assign char_done   = bit_event && state == ST_STOP;
  // Falling edge only counts after a bit decided as one, near a boundary
  assign resync      = tick && prev_sample && !sample && last_bit
                       && (state == ST_DATA || state == ST_STOP)
                       && (rt >= RT_EARLY || rt <= RT_LATE);

  assign idle_hit   = quiet_bits >= frame_len;
  assign wake_addr  = char_done && c2.standby_request && ctrl.rouse_addr && msb;
  assign wake_idle  = c2.standby_request && !ctrl.rouse_addr && idle_hit;
  assign accept     = char_done && (!c2.standby_request || wake_addr);
  assign idle_event = idle_armed && idle_hit && !c2.standby_request;

  // Reception sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state     <= ST_HUNT;
      rt        <= RT_1;
      ones_cnt  <= 2'h0;
      bit_idx   <= 4'h0;
      votes     <= 2'h0;
      noise_acc <= 1'b0;
      last_bit  <= 1'b0;
      shift     <= 9'h000;
    end else if (!ctrl.rx_on) begin
      state    <= ST_HUNT;
      ones_cnt <= 2'h0;
    end else if (tick) begin
      case (state)
        ST_HUNT: begin
          if (sample) begin
            if (ones_cnt != 2'h3) begin
              ones_cnt <= ones_cnt + 2'h1;
            end
          end else begin
            ones_cnt <= 2'h0;
            if (start_found) begin
              state     <= ST_START;
              rt        <= RT_2;
              noise_acc <= 1'b0;
              last_bit  <= 1'b0;
              bit_idx   <= 4'h0;
              shift     <= 9'h000;
            end
          end
        end
        ST_START: begin
          rt <= rt + 5'h01;
          if (rt == RT_3 || rt == RT_8) begin
            votes[0] <= sample;
          end
          if (rt == RT_5 || rt == RT_9) begin
            votes[1] <= sample;
          end
          if (rt == RT_7) begin
            if (vote_ones >= 2'h2) begin
              state    <= ST_HUNT;
              ones_cnt <= 2'h0;
            end else if (vote_ones == 2'h1) begin
              noise_acc <= 1'b1;
            end
          end
          if (rt == RT_10 && vote_ones != 2'h0) begin
            noise_acc <= 1'b1;
          end
          if (rt == RT_16) begin
            state <= ST_DATA;
            rt    <= RT_1;
          end
        end
        default: begin
          rt <= rt + 5'h01;
          if (rt == RT_8) begin
            votes[0] <= sample;
          end
          if (rt == RT_9) begin
            votes[1] <= sample;
          end
          if (bit_event) begin
            noise_acc <= noise_acc | vote_mixed;
            last_bit  <= vote_bit;
            if (state == ST_DATA) begin
              shift[bit_idx] <= vote_bit;
            end else begin
              state    <= ST_HUNT;
              ones_cnt <= vote_bit ? 2'h3 : 2'h0;
            end
          end
          if (resync) begin
            rt <= RT_2;
          end
          if (state == ST_DATA && (rt == RT_16 || (resync && rt >= RT_EARLY))) begin
            if (!resync) begin
              rt <= RT_1;
            end
            if (bit_idx == last_idx) begin
              state <= ST_STOP;
            end else begin
              bit_idx <= bit_idx + 4'h1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_sample <= 1'b1;
    end else if (tick) begin
      prev_sample <= sample;
    end
  end

  // Quiet line counting in bit times
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      quiet_ticks <= 4'h0;
      quiet_bits  <= 4'h0;
      idle_armed  <= 1'b0;
    end else begin
      if (idle_event || wake_idle) begin
        idle_armed <= 1'b0;
      end
      if (start_found) begin
        quiet_ticks <= 4'h0;
        quiet_bits  <= 4'h0;
        idle_armed  <= 1'b1;
      end else if (bit_event) begin
        quiet_ticks <= 4'h0;
        if (vote_bit && !ctrl.quiet_count_origin && quiet_bits != 4'hF) begin
          quiet_bits <= quiet_bits + 4'h1;
        end else begin
          quiet_bits <= 4'h0;
        end
      end else if (tick && state == ST_HUNT) begin
        if (!sample) begin
          quiet_ticks <= 4'h0;
          quiet_bits  <= 4'h0;
        end else begin
          quiet_ticks <= quiet_ticks + 4'h1;
          if (quiet_ticks == 4'hF && quiet_bits != 4'hF) begin
            quiet_bits <= quiet_bits + 4'h1;
          end
        end
      end
    end
  end

  // Buffer and flags; read of the buffer counts as done before a new arrival
  assign rd_take       = arvalid && arready;
  assign rd_clear_full = rd_take && araddr == OFF_DATA;
  assign do_write      = aw_ok && w_ok && !bvalid;
  assign clr = (do_write && wr_addr == OFF_STATUS && wr_strb[0]) ? wr_data[SB_COUNT-1:0]
                                                                 : '0;
  assign set_new = accept && (!full_flag || rd_clear_full);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_buffer  <= 9'h000;
      full_flag    <= 1'b0;
      idle_flag    <= 1'b0;
      overrun_flag <= 1'b0;
      noise_flag   <= 1'b0;
      framing_flag <= 1'b0;
      parity_flag  <= 1'b0;
    end else begin
      if (set_new) begin
        data_buffer <= shift;
      end
      full_flag    <= (full_flag && !rd_clear_full && !clr[SB_FULL]) || set_new;
      idle_flag    <= (idle_flag && !clr[SB_IDLE]) || idle_event;
      overrun_flag <= (overrun_flag && !clr[SB_OVERRUN])
                      || (accept && full_flag && !rd_clear_full);
      noise_flag   <= (noise_flag && !clr[SB_NOISE])
                      || (set_new && (noise_acc || vote_mixed));
      framing_flag <= (framing_flag && !clr[SB_FRAMING]) || (set_new && !vote_bit);
      parity_flag  <= (parity_flag && !clr[SB_PARITY]) || (set_new && par_err);
    end
  end

  // Interrupt requests, silenced in standby
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_irq  <= 1'b0;
      err_irq <= 1'b0;
    end else begin
      rx_irq  <= !c2.standby_request
                 && ((full_flag && c2.receive_full_irq_enable)
                     || (idle_flag && c2.quiet_line_irq_enable));
      err_irq <= !c2.standby_request
                 && ((overrun_flag && c3.overrun_irq_enable)
                     || (noise_flag && c3.noise_irq_enable)
                     || (framing_flag && c3.framing_irq_enable)
                     || (parity_flag && c3.parity_irq_enable));
    end
  end

  // Software registers; a write setting standby beats a wake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl    <= '0;
      c2      <= '0;
      c3      <= '0;
      divisor <= DIV_W'(DIVISOR_RESET);
    end else begin
      if (wake_addr || wake_idle) begin
        c2.standby_request <= 1'b0;
      end
      if (do_write && wr_strb[0]) begin
        if (wr_addr == OFF_CTRL_ONE) begin
          ctrl <= wr_data[$bits(urr_ctrl_type)-1:0];
        end else if (wr_addr == OFF_CTRL_TWO) begin
          c2 <= wr_data[$bits(urr_c2_type)-1:0];
        end else if (wr_addr == OFF_CTRL_THREE) begin
          c3 <= wr_data[$bits(urr_c3_type)-1:0];
        end else if (wr_addr == OFF_DIVISOR) begin
          divisor[7:0] <= wr_data[7:0];
        end
      end
      if (do_write && wr_strb[1] && wr_addr == OFF_DIVISOR) begin
        divisor[DIV_W-1:8] <= wr_data[DIV_W-1:8];
      end
    end
  end

  always_comb begin
    status_word              = '0;
    status_word[SB_FULL]     = full_flag;
    status_word[SB_IDLE]     = idle_flag;
    status_word[SB_OVERRUN]  = overrun_flag;
    status_word[SB_NOISE]    = noise_flag;
    status_word[SB_FRAMING]  = framing_flag;
    status_word[SB_PARITY]   = parity_flag;
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (araddr == OFF_DATA) begin
      rd_word[8:0] = data_buffer;
    end else if (araddr == OFF_STATUS) begin
      rd_word[SB_COUNT-1:0] = status_word;
    end else if (araddr == OFF_CTRL_ONE) begin
      rd_word[$bits(urr_ctrl_type)-1:0] = ctrl;
    end else if (araddr == OFF_CTRL_TWO) begin
      rd_word[$bits(urr_c2_type)-1:0] = c2;
    end else if (araddr == OFF_CTRL_THREE) begin
      rd_word[$bits(urr_c3_type)-1:0] = c3;
    end else if (araddr == OFF_DIVISOR) begin
      rd_word[DIV_W-1:0] = divisor;
    end else begin
      rd_ok = 1'b0;
    end
  end

  assign wr_ok = wr_addr == OFF_DATA || wr_addr == OFF_STATUS || wr_addr == OFF_CTRL_ONE
                 || wr_addr == OFF_CTRL_TWO || wr_addr == OFF_CTRL_THREE
                 || wr_addr == OFF_DIVISOR;

  // AXI4-Lite write side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      aw_ok   <= 1'b0;
      w_ok    <= 1'b0;
      wr_addr <= '0;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        wr_addr <= awaddr;
        aw_ok   <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wr_data <= wdata;
        wr_strb <= wstrb;
        w_ok    <= 1'b1;
        wready  <= 1'b0;
      end
      if (do_write) begin
        aw_ok  <= 1'b0;
        w_ok   <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else begin
      if (rd_take) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_word;
        rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule

//--- hw/urr_pkg.sv
// Contract
// - Input is sampled on a tick running at sixteen times the baud rate.
// - Tick count restarts after each start bit and each one-to-zero data change.
// - Start search wants a zero after three ones; edge starts the 16-tick count.
// - Start verified at ticks 3, 5, 7; one high sample means noise.
// - Two or more high verification samples abandon the start and resume hunting.
// - Data bit is majority of ticks 8, 9, 10; disagreement flags noise.
// - Start ticks 8-10 never cancel a verified start; any high sets noise.
// - Stop bit majority of ticks 8-10; zeros give framing error, disagreement noise.
// - Framing error, breaks included, is set together with receive-full.
// - Valid falling edges inside a character realign the tick count.
// - Standby request suppresses every receiver interrupt request.
// - Address-mark wake: MSB one clears standby and sets receive-full.
// - Idle-line wake clears standby without setting idle or receive-full.
// - Quiet count origin picks start bit or stop bit as idle count start.
// - Standby set on an already idle line may wake at once.
// - Receive-full set on transfer to buffer; interrupts when enabled.
// - Idle flag after 10 or 11 ones; interrupts when quiet enable set.
// - Overrun keeps old character, drops new, requests error interrupt if enabled.
// - Noise in any start, data or stop bit sets noise; error interrupt (here only when the noise enable is set).
// - Framing error requests an error interrupt when its enable is set.
// - Parity mismatch sets parity error; error interrupt when enabled.
// - Rouse select one means address mark, zero idle line; reset clears.
// - Quiet origin one counts after stop bit, zero after start bit.
// - Length select gives 8 or 9 data bits, 10 or 11 bit frames.
package urr_pkg;
  localparam int ADDR_W = 6;

  localparam logic [ADDR_W-1:0] OFF_DATA        = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS      = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_CTRL_ONE    = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_CTRL_TWO    = 6'h0C;
  localparam logic [ADDR_W-1:0] OFF_CTRL_THREE  = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_DIVISOR     = 6'h14;

  localparam int SB_FULL    = 0;
  localparam int SB_IDLE    = 1;
  localparam int SB_OVERRUN = 2;
  localparam int SB_NOISE   = 3;
  localparam int SB_FRAMING = 4;
  localparam int SB_PARITY  = 5;
  localparam int SB_COUNT   = 6;

  localparam logic [15:0] DIVISOR_RESET = 16'h0041;

  localparam logic [4:0] RT_1     = 5'h01;
  localparam logic [4:0] RT_2     = 5'h02;
  localparam logic [4:0] RT_3     = 5'h03;
  localparam logic [4:0] RT_5     = 5'h05;
  localparam logic [4:0] RT_7     = 5'h07;
  localparam logic [4:0] RT_8     = 5'h08;
  localparam logic [4:0] RT_9     = 5'h09;
  localparam logic [4:0] RT_10    = 5'h0A;
  localparam logic [4:0] RT_LATE  = 5'h04;
  localparam logic [4:0] RT_EARLY = 5'h0C;
  localparam logic [4:0] RT_16    = 5'h10;

  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;
  localparam logic [3:0] FRAME_LEN_8 = 4'hA;
  localparam logic [3:0] FRAME_LEN_9 = 4'hB;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_HUNT  = 2'b00,
    ST_START = 2'b01,
    ST_DATA  = 2'b10,
    ST_STOP  = 2'b11
  } urr_state_type;

  // Control one, bit 0 is receiver enable
  typedef struct packed {
    logic odd_parity_select;
    logic parity_on;
    logic quiet_count_origin;
    logic rouse_addr;
    logic nine_bit;
    logic rx_on;
  } urr_ctrl_type;

  typedef struct packed {
    logic standby_request;
    logic quiet_line_irq_enable;
    logic receive_full_irq_enable;
  } urr_c2_type;

  typedef struct packed {
    logic parity_irq_enable;
    logic framing_irq_enable;
    logic noise_irq_enable;
    logic overrun_irq_enable;
  } urr_c3_type;
endpackage

//--- hw/urr_tick_gen.sv
`timescale 1ns/10ps
module urr_tick_gen #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Divisor in clock cycles per tick
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  tick
);
  logic [DIV_W-1:0] count;

  // Zero divisor behaves as one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (divisor == '0 || count >= divisor - DIV_W'(1)) begin
      count <= '0;
      tick  <= 1'b1;
    end else begin
      count <= count + DIV_W'(1);
      tick  <= 1'b0;
    end
  end
endmodule

//--- sim/urr_serial_src.sv
`timescale 1ns/10ps
module urr_serial_src (
  // Clock
  input  wire logic aclk,
  // Line toward the receiver
  output logic      line
);
  // Idle high, so every start is preceded by ones
  initial line = 1'b1;
  // One frame, one clock of it inverted at glitch (negative: none)
  task automatic send(input logic [8:0] d, input int nd, input logic stop, input int glitch);
    logic [10:0] fr;
    fr = {2'b11, d} << 1;
    fr[nd + 1] = stop;
    for (int i = 0; i < (nd + 2) * 16; i++) begin
      @(posedge aclk);
      line <= fr[i / 16] ^ (i == glitch);
    end
    @(posedge aclk);
    line <= 1'b1;
  endtask
  // Short low pulse that is no real start
  task automatic pulse(input int n);
    @(posedge aclk);
    line <= 1'b0;
    repeat (n) @(posedge aclk);
    line <= 1'b1;
  endtask
endmodule

//--- sim/urr_receiver_sva.sv
`timescale 1ns/10ps
module urr_receiver_sva (
  // Clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // Bus request and response side
  input  wire logic                       awvalid,
  input  wire logic                       awready,
  input  wire logic                       wvalid,
  input  wire logic                       wready,
  input  wire logic                       bvalid,
  input  wire logic                       bready,
  input  wire logic [1:0]                 bresp,
  input  wire logic                       arvalid,
  input  wire logic                       arready,
  input  wire logic                       rvalid,
  input  wire logic                       rready,
  input  wire logic [31:0]                rdata,
  input  wire logic [1:0]                 rresp,
  // Interrupts
  input  wire logic                       rx_irq,
  input  wire logic                       err_irq
);
  import urr_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rst_out;
    $rose(aresetn) |-> !bvalid && !rvalid && !rx_irq && !err_irq && awready && arready;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not idle after reset");
  property p_wr_ans;
    awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer timing wrong");
  property p_rd_ans;
    arvalid && arready |=> rvalid && !arready;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer timing wrong");
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_b_done;
    bvalid && bready |=> !bvalid && awready && wready;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write channel not freed");
  property p_r_done;
    rvalid && rready |=> !rvalid && arready;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read channel not freed");
  property p_err_zero;
    rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read carries data");
  c_write: cover property (bvalid && bready);
  c_slverr: cover property (rvalid && rresp == RESP_SLVERR);
  c_rx_irq: cover property ($rose(rx_irq));
  c_err_irq: cover property ($rose(err_irq));
endmodule
bind urr_receiver urr_receiver_sva chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
  .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .rresp, .rx_irq,
  .err_irq);

//--- sim/urr_receiver_bench.sv
`timescale 1ns/10ps
module urr_receiver_bench;
  import urr_pkg::*;
  logic        aclk, aresetn, serial_in, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, rx_irq, err_irq;
  logic [5:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rr;
  int          error_cnt, n_tests;
  urr_serial_src src (.aclk(aclk), .line(serial_in));
  urr_receiver dut (.aclk(aclk), .aresetn(aresetn), .serial_in(serial_in), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .rx_irq(rx_irq), .err_irq(err_irq));
  always #50 aclk = ~aclk;
  task stop_test;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rr = bresp;
    bready <= 1'b0;
  endtask
  task rd(input logic [5:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rv = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  task st(input logic [31:0] m, input logic [31:0] e);
    rd(OFF_STATUS);
    chk("status", e, rv & m);
  endtask
  task dat(input logic [31:0] e);
    rd(OFF_DATA);
    chk("data", e, rv);
  endtask
  task settle;
    repeat (4) @(posedge aclk);
  endtask
  task t_basic;
    wr(OFF_CTRL_TWO, 32'h1);
    src.send(9'h0A5, 8, 1'b1, -1);
    settle();
    chk("rx_irq", 32'h1, rx_irq);
    st(32'h3D, 32'h01);
    dat(32'h0A5);
    repeat (200) @(posedge aclk);
    st(32'h02, 32'h02);
    wr(OFF_STATUS, 32'h3F);
    wr(OFF_CTRL_TWO, 32'h0);
  endtask
  task t_errors;
    wr(OFF_CTRL_THREE, 32'h5);
    src.send(9'h000, 8, 1'b0, -1);
    settle();
    st(32'h3D, 32'h11);
    chk("err_irq", 32'h1, err_irq);
    dat(32'h0);
    wr(OFF_STATUS, 32'h3F);
    src.send(9'h03C, 8, 1'b1, -1);
    src.send(9'h0C3, 8, 1'b1, -1);
    settle();
    st(32'h3D, 32'h05);
    chk("err_irq", 32'h1, err_irq);
    dat(32'h03C);
    wr(OFF_STATUS, 32'h3F);
    wr(OFF_CTRL_THREE, 32'h2);
    src.send(9'h0A5, 8, 1'b1, 24);
    settle();
    st(32'h3D, 32'h09);
    chk("err_irq", 32'h1, err_irq);
    dat(32'h0A5);
    wr(OFF_STATUS, 32'h3F);
    // Glitch lands on tick 9 of the start bit
    src.send(9'h0A5, 8, 1'b1, 8);
    settle();
    st(32'h3D, 32'h09);
    dat(32'h0A5);
    wr(OFF_STATUS, 32'h3F);
  endtask
  task t_start_and_parity;
    src.pulse(2);
    repeat (20) @(posedge aclk);
    src.send(9'h05A, 8, 1'b1, -1);
    settle();
    st(32'h3D, 32'h01);
    dat(32'h05A);
    wr(OFF_CTRL_ONE, 32'h11);
    wr(OFF_CTRL_THREE, 32'h8);
    src.send(9'h001, 8, 1'b1, -1);
    settle();
    st(32'h3D, 32'h21);
    chk("err_irq", 32'h1, err_irq);
    wr(OFF_STATUS, 32'h3F);
    wr(OFF_CTRL_ONE, 32'h31);
    src.send(9'h001, 8, 1'b1, -1);
    settle();
    st(32'h3D, 32'h01);
    wr(OFF_STATUS, 32'h3F);
    wr(OFF_CTRL_THREE, 32'h0);
  endtask
  task t_wake;
    wr(OFF_CTRL_ONE, 32'h05);
    wr(OFF_CTRL_TWO, 32'h05);
    src.send(9'h012, 8, 1'b1, -1);
    settle();
    chk("rx_irq", 32'h0, rx_irq);
    st(32'h01, 32'h00);
    src.send(9'h092, 8, 1'b1, -1);
    settle();
    st(32'h01, 32'h01);
    rd(OFF_CTRL_TWO);
    chk("ctrl_two", 32'h01, rv);
    dat(32'h092);
    // Nine bits, idle-line wake, quiet count after stop
    wr(OFF_CTRL_ONE, 32'h0B);
    src.send(9'h1A5, 9, 1'b1, -1);
    settle();
    chk("rx_irq", 32'h1, rx_irq);
    wr(OFF_CTRL_TWO, 32'h05);
    settle();
    chk("rx_irq", 32'h0, rx_irq);
    // Count from the stop bit has not reached eleven bits yet
    repeat (120) @(posedge aclk);
    rd(OFF_CTRL_TWO);
    chk("ctrl_two", 32'h05, rv);
    repeat (60) @(posedge aclk);
    rd(OFF_CTRL_TWO);
    chk("ctrl_two", 32'h01, rv);
    st(32'h03, 32'h01);
    // Standby on an already idle line wakes at once
    wr(OFF_CTRL_TWO, 32'h05);
    rd(OFF_CTRL_TWO);
    chk("ctrl_two", 32'h01, rv);
    dat(32'h1A5);
    rd(6'h3C);
    chk("unmapped", 32'h2, {30'h0, rr});
    wr(6'h3C, 32'h0);
    chk("bresp", 32'h2, {30'h0, rr});
  endtask
  initial begin
    aclk = 1'b0; aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 6'h00; araddr = 6'h00; wdata = 32'h0;
    wstrb = 4'hF;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    wr(OFF_DIVISOR, 32'h1);
    wr(OFF_CTRL_ONE, 32'h1);
    t_basic();
    t_errors();
    t_start_and_parity();
    t_wake();
    stop_test();
  end
  initial begin
    #2000000;
    error_cnt++;
    $display("[ERR] watchdog expected done seen hang");
    stop_test();
  end
endmodule
